// ### hw/acs_pkg.sv
// package: constants, register map and types of the calibration sequencer
package acs_pkg;

    // ****************************************
    // timing
    // ****************************************
    localparam int CLK_PERIOD_NS = 50;
    // notch rates are given at this reference master clock and scale with the clock
    localparam int REF_MCLK_HZ = 2457600;
    localparam int NOTCH0_HZ = 50;
    localparam int NOTCH1_HZ = 60;
    localparam int NOTCH2_HZ = 250;
    localparam int NOTCH3_HZ = 500;
    // one output period in master clocks, which are our clocks
    localparam int PERIOD0_CYC = REF_MCLK_HZ / NOTCH0_HZ;
    localparam int PERIOD1_CYC = REF_MCLK_HZ / NOTCH1_HZ;
    localparam int PERIOD2_CYC = REF_MCLK_HZ / NOTCH2_HZ;
    localparam int PERIOD3_CYC = REF_MCLK_HZ / NOTCH3_HZ;
    localparam int SCALE_DELAY_MCLK = 2000;
    localparam int SCALE_DELAY_NS = SCALE_DELAY_MCLK * CLK_PERIOD_NS;
    localparam int SCALE_DELAY_CYC = SCALE_DELAY_NS / CLK_PERIOD_NS;

    // ****************************************
    // calibration lengths in output periods
    // ****************************************
    localparam logic [3:0] SELF_MODE_PER = 4'h6;
    localparam logic [3:0] SELF_READY_PER = 4'h9;
    localparam logic [3:0] SYS_MODE_PER = 4'h3;
    localparam logic [3:0] SYS_READY_PER = 4'h4;
    localparam logic [3:0] SELF_ZERO_PER = 4'h3;

    // ****************************************
    // register map
    // ****************************************
    localparam int ADDR_W = 8;
    localparam logic [7:0] SETUP_OFS = 8'h00;
    localparam logic [7:0] RESULT_OFS = 8'h04;
    localparam logic [7:0] STATUS_OFS = 8'h08;
    localparam logic [7:0] MASK_OFS = 8'h0C;
    localparam logic [7:0] STATE_OFS = 8'h10;
    localparam int STAT_CAL_DONE = 0;
    localparam int STAT_RESULT = 1;
    localparam logic [6:0] SETUP_RST = 7'h00;
    localparam logic [1:0] MASK_RST = 2'h0;

    typedef enum logic [1:0] {
        OP_NORMAL = 2'h0,
        OP_SELF_CAL = 2'h1,
        OP_ZERO_SYS = 2'h2,
        OP_FULL_SYS = 2'h3
    } acs_op_e;

    typedef enum logic [2:0] {
        STEP_NONE = 3'h0,
        STEP_ZERO_INT = 3'h1,
        STEP_FULL_INT = 3'h2,
        STEP_ZERO_SYS = 3'h3,
        STEP_FULL_SYS = 3'h4
    } acs_step_e;

    typedef enum logic [1:0] {
        PH_CONVERT = 2'b00,
        PH_CAL = 2'b01,
        PH_SETTLE = 2'b11,
        PH_SCALE = 2'b10
    } acs_phase_e;

    // setup register, bits [6:0]: gain, buffer, rate select, op select
    typedef struct packed {
        logic [1:0] gain;
        logic buffered;
        logic rate_select_hi;
        logic rate_select_lo;
        logic op_select_hi;
        logic op_select_lo;
    } acs_cfg_s;

endpackage

// ### hw/acs_top.sv
// top: calibration and conversion sequencer with an AHB-Lite register slave
// Contract
// - result_ready_n falls when a calibration sequence has finished.
// - each calibration is followed by one normal conversion whose result is then in the result register.
// - a completed calibration returns the op select bits to 0,0.
// - op select clears before result_ready_n falls, and that clearing says nothing about new data.
// - start to result_ready_n covers calibration, one conversion and a 2000 clock scaling delay.
// - code 0,1 runs internal zero then full scale; op bits clear after 6 periods, ready after 9 plus delay.
// - code 1,0 runs a system zero scale; op bits clear after 3 periods, ready after 4 plus delay.
// - code 1,1 runs a system full scale; op bits clear after 3 periods, ready after 4 plus delay.
// - two rate select bits pick 50, 60, 250 or 500 Hz output rate, scaled with the clock.
// - the buffer bit at 0 selects unbuffered input and at 1 buffered input.
// - the result register is read-only, 16 bits, and holds the newest result.
// - a write to the result register completes and its data are discarded.
module acs_top
    import acs_pkg::*;
#(
    parameter int PERIOD0 = PERIOD0_CYC,
    parameter int PERIOD1 = PERIOD1_CYC,
    parameter int PERIOD2 = PERIOD2_CYC,
    parameter int PERIOD3 = PERIOD3_CYC
) (
    input wire logic CLK_SYS,
    input wire logic RST_N,
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    input wire logic [15:0] FILTER_DATA,
    output logic RESULT_READY_N,
    output logic IRQ,
    output logic BUF_ENABLE,
    output logic [1:0] GAIN_SELECT,
    output logic [2:0] CAL_STEP
);

    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        acs_phase_e phase;
        acs_cfg_s cfg;
        acs_step_e step;
        logic [15:0] period_cnt;
        logic [3:0] per_idx;
        logic [10:0] scale_cnt;
        logic [15:0] hold;
        logic [15:0] result;
        logic rdy_n;
        logic [1:0] status;
        logic [1:0] mask;
        logic irq;
        logic [31:0] hrdata;
        logic hready;
        logic wr_pend;
        logic [7:0] wr_addr;
    } acs_state_s;

    acs_state_s r;
    acs_state_s next_r;

    logic [15:0] period_len;
    logic [15:0] wr_len;
    logic tick;
    logic take;
    logic [7:0] addr;
    logic [3:0] mode_len;
    logic [3:0] ready_len;
    acs_op_e op_cur;
    acs_cfg_s wcfg;

    // output period from the rate select bits
    always_comb begin
        unique case ({r.cfg.rate_select_hi, r.cfg.rate_select_lo})
            2'h0: period_len = 16'(PERIOD0);
            2'h1: period_len = 16'(PERIOD1);
            2'h2: period_len = 16'(PERIOD2);
            2'h3: period_len = 16'(PERIOD3);
        endcase
    end

    // period of the rate being written, so the first period after a rate change has its new length
    always_comb begin
        unique case ({wcfg.rate_select_hi, wcfg.rate_select_lo})
            2'h0: wr_len = 16'(PERIOD0);
            2'h1: wr_len = 16'(PERIOD1);
            2'h2: wr_len = 16'(PERIOD2);
            2'h3: wr_len = 16'(PERIOD3);
        endcase
    end

    assign tick = (r.period_cnt == 16'h0000);
    assign take = HSEL & HTRANS[1] & HREADY;
    assign addr = HADDR[ADDR_W-1:0];
    assign op_cur = acs_op_e'({r.cfg.op_select_hi, r.cfg.op_select_lo});
    assign mode_len = (op_cur == OP_SELF_CAL) ? SELF_MODE_PER : SYS_MODE_PER;
    assign ready_len = (op_cur == OP_SELF_CAL) ? SELF_READY_PER : SYS_READY_PER;
    assign wcfg = acs_cfg_s'(HWDATA[6:0]);

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        next_r = r;
        next_r.period_cnt = tick ? period_len - 16'h0001 : r.period_cnt - 16'h0001;

        // bus address phase: reads answer in the data phase, writes take one wait
        if (take && !HWRITE) begin
            unique case (addr)
                SETUP_OFS: next_r.hrdata = {25'h0000000, r.cfg};
                RESULT_OFS: begin
                    next_r.hrdata = {16'h0000, r.result};
                    next_r.rdy_n = 1'b1;
                end
                STATUS_OFS: begin
                    next_r.hrdata = {30'h00000000, r.status};
                    next_r.status = 2'h0;
                end
                MASK_OFS: next_r.hrdata = {30'h00000000, r.mask};
                STATE_OFS: next_r.hrdata = {29'h00000000, r.phase, r.rdy_n};
                default: next_r.hrdata = 32'h00000000;
            endcase
        end
        next_r.hready = 1'b1;
        next_r.wr_pend = 1'b0;
        if (take && HWRITE) begin
            next_r.hready = 1'b0;
            next_r.wr_pend = 1'b1;
            next_r.wr_addr = addr;
        end

        // sequencer
        unique case (r.phase)
            PH_CONVERT: begin
                if (tick) begin
                    next_r.result = FILTER_DATA;
                    next_r.rdy_n = 1'b0;
                    next_r.status[STAT_RESULT] = 1'b1;
                end
            end
            PH_CAL: begin
                next_r.rdy_n = 1'b1;
                if (tick) begin
                    next_r.per_idx = r.per_idx + 4'h1;
                    if (op_cur == OP_SELF_CAL && r.per_idx + 4'h1 == SELF_ZERO_PER) begin
                        next_r.step = STEP_FULL_INT;
                    end
                    if (r.per_idx + 4'h1 == mode_len) begin
                        next_r.cfg.op_select_hi = 1'b0;
                        next_r.cfg.op_select_lo = 1'b0;
                        next_r.status[STAT_CAL_DONE] = 1'b1;
                        next_r.step = STEP_NONE;
                        next_r.phase = PH_SETTLE;
                        next_r.scale_cnt = {7'h00, ready_len};
                    end
                end
            end
            PH_SETTLE: begin
                // scale_cnt holds the ready length of the code that was cleared
                next_r.rdy_n = 1'b1;
                if (tick) begin
                    next_r.per_idx = r.per_idx + 4'h1;
                    if (r.per_idx + 4'h1 == r.scale_cnt[3:0]) begin
                        next_r.hold = FILTER_DATA;
                        next_r.scale_cnt = 11'(SCALE_DELAY_CYC - 1);
                        next_r.phase = PH_SCALE;
                    end
                end
            end
            PH_SCALE: begin
                next_r.rdy_n = 1'b1;
                next_r.scale_cnt = r.scale_cnt - 11'h001;
                if (r.scale_cnt == 11'h000) begin
                    next_r.result = r.hold;
                    next_r.rdy_n = 1'b0;
                    next_r.status[STAT_RESULT] = 1'b1;
                    next_r.phase = PH_CONVERT;
                    next_r.period_cnt = period_len - 16'h0001;
                end
            end
        endcase

        // write data phase
        if (r.wr_pend) begin
            unique case (r.wr_addr)
                SETUP_OFS: begin
                    // setup is frozen while a sequence runs
                    if (r.phase == PH_CONVERT) begin
                        next_r.cfg = wcfg;
                        next_r.period_cnt = wr_len - 16'h0001;
                        if ({wcfg.op_select_hi, wcfg.op_select_lo} != OP_NORMAL) begin
                            next_r.phase = PH_CAL;
                            next_r.per_idx = 4'h0;
                            next_r.rdy_n = 1'b1;
                            unique case ({wcfg.op_select_hi, wcfg.op_select_lo})
                                OP_SELF_CAL: next_r.step = STEP_ZERO_INT;
                                OP_ZERO_SYS: next_r.step = STEP_ZERO_SYS;
                                default: next_r.step = STEP_FULL_SYS;
                            endcase
                        end
                    end
                end
                MASK_OFS: next_r.mask = HWDATA[1:0];
                default: ;
            endcase
        end

        next_r.irq = |(next_r.status & next_r.mask);
    end

    // ****************************************
    // registers
    // ****************************************
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            r <= '0;
            r.phase <= PH_CONVERT;
            r.cfg <= acs_cfg_s'(SETUP_RST);
            r.step <= STEP_NONE;
            r.period_cnt <= 16'(PERIOD0 - 1);
            r.rdy_n <= 1'b1;
            r.mask <= MASK_RST;
            r.hready <= 1'b1;
        end else begin
            r <= next_r;
        end
    end

    assign HRDATA = r.hrdata;
    assign HREADYOUT = r.hready;
    assign HRESP = 1'b0;
    assign RESULT_READY_N = r.rdy_n;
    assign IRQ = r.irq;
    assign BUF_ENABLE = r.cfg.buffered;
    assign GAIN_SELECT = r.cfg.gain;
    assign CAL_STEP = r.step;

endmodule

// ### verification/acs_filter_model.sv
// model: filter output word handed to the sequencer
module acs_filter_model (
    input wire logic CLK_SYS,
    input wire logic [15:0] value,
    output logic [15:0] filter_data
);
    timeunit 1ns;
    timeprecision 1ns;
    always_ff @(posedge CLK_SYS) begin
        filter_data <= value;
    end
endmodule

// ### verification/acs_monitor.sv
// checker: bus handshake and calibration step relations at the top ports
module acs_monitor
    import acs_pkg::*;
(
    input wire logic CLK_SYS,
    input wire logic RST_N,
    input wire logic HSEL,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic HREADY,
    input logic HREADYOUT,
    input logic HRESP,
    input logic RESULT_READY_N,
    input logic [2:0] CAL_STEP
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (!RST_N);
    sequence s_addr;
        HSEL && HTRANS[1] && HREADY;
    endsequence
    a_resp_okay: assert property (HRESP == 1'b0) else $error("response not okay");
    a_write_wait: assert property (s_addr ##0 HWRITE |=> !HREADYOUT ##1 HREADYOUT)
        else $error("write wait state wrong");
    a_read_nowait: assert property (s_addr ##0 !HWRITE |=> HREADYOUT)
        else $error("read stalled");
    a_cal_hides_ready: assert property (CAL_STEP != 3'h0 |-> RESULT_READY_N)
        else $error("ready low during calibration");
    a_ready_when_idle: assert property ($fell(RESULT_READY_N) |-> CAL_STEP == 3'h0)
        else $error("ready fell with step active");
    a_self_order: assert property ($past(CAL_STEP) == 3'h1 && CAL_STEP != 3'h1
        |-> CAL_STEP == 3'h2) else $error("zero step not followed by full step");
    a_self_end: assert property ($past(CAL_STEP) == 3'h2 && CAL_STEP != 3'h2
        |-> CAL_STEP == 3'h0) else $error("full step not followed by idle");
    a_sys_end: assert property ($past(CAL_STEP) >= 3'h3 && $changed(CAL_STEP)
        |-> CAL_STEP == 3'h0) else $error("system step not followed by idle");
endmodule

bind acs_top acs_monitor u_mon (.CLK_SYS(CLK_SYS), .RST_N(RST_N), .HSEL(HSEL),
    .HTRANS(HTRANS), .HWRITE(HWRITE), .HREADY(HREADY), .HREADYOUT(HREADYOUT),
    .HRESP(HRESP), .RESULT_READY_N(RESULT_READY_N), .CAL_STEP(CAL_STEP));

// ### verification/adc_calibration_sequencer_test.sv
// testbench: calibration sequences, registers and interrupt of the sequencer
module adc_calibration_sequencer_test
    import acs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int P [4] = '{40, 30, 20, 10};
    typedef struct {logic [6:0] cfg; int ml; int rl; logic [15:0] fd;
        logic [2:0] st;} acs_row_s;
    // ****************************************
    // rows: setup word, op-clear periods, ready periods, filter word, first step
    // ****************************************
    acs_row_s rows [4] = '{'{7'h51, 6, 9, 16'hA5C3, 3'h1}, '{7'h26, 3, 4, 16'h5A3C, 3'h3},
        '{7'h7B, 3, 4, 16'hFFFF, 3'h4}, '{7'h0D, 6, 9, 16'h0001, 3'h1}};
    logic CLK_SYS, RST_N, HSEL, HWRITE, HREADYOUT, HRESP, RESULT_READY_N, IRQ, BUF_ENABLE;
    logic [31:0] HADDR, HWDATA, HRDATA, rd;
    logic [1:0] HTRANS, GAIN_SELECT;
    logic [2:0] HSIZE, CAL_STEP;
    logic [15:0] FILTER_DATA, fval;
    int num_errors = 0, n_checks = 0, cyc = 0, t0;
    acs_top #(.PERIOD0(40), .PERIOD1(30), .PERIOD2(20), .PERIOD3(10)) dut (
        .CLK_SYS(CLK_SYS), .RST_N(RST_N), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
        .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADYOUT),
        .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .FILTER_DATA(FILTER_DATA),
        .RESULT_READY_N(RESULT_READY_N), .IRQ(IRQ), .BUF_ENABLE(BUF_ENABLE),
        .GAIN_SELECT(GAIN_SELECT), .CAL_STEP(CAL_STEP));
    acs_filter_model src (.CLK_SYS(CLK_SYS), .value(fval), .filter_data(FILTER_DATA));
    initial begin
        CLK_SYS = 1'b0;
        forever #25 CLK_SYS = ~CLK_SYS;
    end
    always @(posedge CLK_SYS) cyc <= cyc + 1;
    task automatic final_report();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %0t %s", $time, m);
        end
    endtask
    // waits for ready (s=1) or for the step to go idle (s=0), bounded
    task automatic wt(input logic s);
        int k;
        k = 0;
        while ((s ? RESULT_READY_N : CAL_STEP != 3'h0) !== 1'b0) begin
            @(posedge CLK_SYS);
            k++;
            if (k > 30000) begin
                num_errors++;
                final_report();
            end
        end
    endtask
    task automatic rdy();
        int k;
        k = 0;
        @(posedge CLK_SYS);
        while (HREADYOUT !== 1'b1) begin
            @(posedge CLK_SYS);
            k++;
            if (k > 20) begin
                num_errors++;
                final_report();
            end
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        HSEL <= 1'b1;
        HTRANS <= 2'h2;
        HADDR <= {24'h0, a};
        HWRITE <= w;
        rdy();
        HSEL <= 1'b0;
        HTRANS <= 2'h0;
        HWDATA <= d;
        rdy();
        rd = HRDATA;
    endtask
    function automatic logic near(int n, int e);
        return n >= e - 2 && n <= e + 2;
    endfunction
    initial begin
        RST_N = 1'b0;
        HSEL = 1'b0;
        HTRANS = 2'h0;
        HADDR = 32'h0;
        HWRITE = 1'b0;
        HWDATA = 32'h0;
        HSIZE = 3'h2;
        fval = 16'h1234;
        repeat (5) @(posedge CLK_SYS);
        RST_N <= 1'b1;
        @(posedge CLK_SYS);
        chk(32'(RESULT_READY_N), 32'h1, "ready idle after reset");
        bus(1'b0, SETUP_OFS, 32'h0);
        chk(rd, 32'h0, "setup reset value");
        bus(1'b0, 8'h20, 32'h0);
        chk(rd, 32'h0, "unmapped read");
        wt(1'b1);
        chk(32'(IRQ), 32'h0, "masked event raised irq");
        // written just after a conversion, so no newer result can hide the write
        bus(1'b1, RESULT_OFS, 32'h0000BEEF);
        bus(1'b0, RESULT_OFS, 32'h0);
        chk(rd, 32'h1234, "result after discarded write");
        bus(1'b1, MASK_OFS, 32'h1);
        bus(1'b0, MASK_OFS, 32'h0);
        chk(rd, 32'h1, "mask readback");
        bus(1'b0, STATUS_OFS, 32'h0);
        // ****************************************
        // one calibration per row
        // ****************************************
        foreach (rows[i]) begin
            fval <= rows[i].fd;
            bus(1'b1, SETUP_OFS, {25'h0, rows[i].cfg});
            t0 = cyc;
            bus(1'b0, SETUP_OFS, 32'h0);
            chk(rd & 32'h3, 32'(rows[i].cfg[1:0]), "op readback");
            chk(32'(CAL_STEP), 32'(rows[i].st), "first step");
            bus(1'b0, STATE_OFS, 32'h0);
            chk(rd, {29'h0, PH_CAL, 1'b1}, "phase readback");
            bus(1'b1, SETUP_OFS, {25'h0, ~rows[i].cfg & 7'h7C});
            chk(32'(GAIN_SELECT), 32'(rows[i].cfg[6:5]), "gain changed");
            chk(32'(BUF_ENABLE), 32'(rows[i].cfg[4]), "buffer select");
            wt(1'b0);
            chk(32'(near(cyc - t0, rows[i].ml * P[rows[i].cfg[3:2]])), 32'h1, "op time");
            bus(1'b0, SETUP_OFS, 32'h0);
            chk(rd, 32'(rows[i].cfg & 7'h7C), "op not cleared");
            chk(32'(RESULT_READY_N), 32'h1, "ready with op clear");
            wt(1'b1);
            chk(32'(near(cyc - t0, rows[i].rl * P[rows[i].cfg[3:2]] + 2000)), 32'h1,
                "ready time");
            chk(32'(IRQ), 32'h1, "irq not raised");
            bus(1'b0, RESULT_OFS, 32'h0);
            chk(rd, 32'(rows[i].fd), "first result");
            bus(1'b0, STATUS_OFS, 32'h0);
            chk(rd & 32'h3, 32'h3, "status bits");
            @(posedge CLK_SYS);
            chk(32'(IRQ), 32'h0, "irq not cleared");
        end
        // ****************************************
        // reset in the middle of a calibration
        // ****************************************
        bus(1'b1, SETUP_OFS, 32'h00000051);
        RST_N <= 1'b0;
        @(posedge CLK_SYS);
        chk(32'(CAL_STEP), 32'h0, "step after reset");
        chk(32'(RESULT_READY_N), 32'h1, "ready after reset");
        chk({29'h0, IRQ, BUF_ENABLE, HREADYOUT}, 32'h1, "outputs after reset");
        chk(32'(GAIN_SELECT), 32'h0, "gain after reset");
        repeat (4) @(posedge CLK_SYS);
        RST_N <= 1'b1;
        @(posedge CLK_SYS);
        bus(1'b0, SETUP_OFS, 32'h0);
        chk(rd, 32'h0, "setup after reset");
        bus(1'b0, MASK_OFS, 32'h0);
        chk(rd, 32'h0, "mask after reset");
        final_report();
    end
endmodule
